//--- bench/reset_cause_regs_tb.sv
module reset_cause_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import reset_cause_pkg::*;

    logic              clk;
    logic              reset;
    logic              ce;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic [3:0]        pstrb;
    logic [3:0]        strb;
    logic              pready;
    logic              pslverr;
    logic [1:0]        bor_cfg;
    logic              armed;
    logic [EV_W-1:0]   ev;
    logic              bor_en;
    logic              irq;
    logic              en;
    int                failures    = 0;
    int                checks_done = 0;
    int                cycles      = 0;
    // Flag values expected after each event, indexed by event status position
    logic [7:0]        exp_lo [EV_W] = '{8'h80, 8'h40, 8'hDF, 8'hEF, 8'hF7, 8'hFB, 8'h3E, 8'hFF, 8'hFF, 8'h00};
    logic [2:0]        exp_hi [EV_W] = '{3'h0, 3'h0, 3'h7, 3'h7, 3'h7, 3'h7, 3'h4, 3'h3, 3'h5, 3'h1};

    reset_cause_regs reset_cause_regs_i (
        .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brownout_config_field(bor_cfg), .brownout_armed_pin(armed),
        .brownout_event(ev[EV_BROWNOUT]), .stack_overflow_event(ev[EV_STACK_OVF]),
        .stack_underflow_event(ev[EV_STACK_UNF]), .wdt_window_event(ev[EV_WDT_WINDOW]),
        .wdt_timeout_event(ev[EV_WDT_TIMEOUT]), .ext_pin_event(ev[EV_EXT_PIN]),
        .reset_instr_event(ev[EV_RESET_INSTR]), .core_reg_event(ev[EV_CORE_REG]),
        .mem_viol_event(ev[EV_MEM_VIOL]), .cfg_mem_event(ev[EV_CFG_MEM]),
        .brownout_enable(bor_en), .irq(irq)
    );

    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            $display("[ERR] run length expected below 20000 seen 20000");
            end_sim();
        end
    end

    task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready, only the hang guard ends the wait
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= strb;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        check("pready wait", n, 32'h1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic xe);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(1'b0, a, 32'h0, r, e);
        check(name, r, exp);
        check({name, " error"}, {31'h0, e}, {31'h0, xe});
    endtask

    // One-cycle event pulse on status position i
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 10'h001 << i;
        @(posedge clk);
        ev <= '0;
    endtask

    // Main sequence
    initial begin
        reset = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; pstrb = 4'hF; strb = 4'hF; bor_cfg = 2'h1; armed = 1'b1; ev = '0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        rd("control reset", ADDR_BROWNOUT_CONTROL, 32'h81, 1'b0);
        rd("low reset", ADDR_RESET_FLAGS_LOW, 32'h3D, 1'b0);
        rd("high reset", ADDR_RESET_FLAGS_HIGH, 32'h4, 1'b0);
        rd("status reset", ADDR_EVENT_STATUS, 32'h0, 1'b0);
        rd("mask reset", ADDR_EVENT_MASK, 32'h0, 1'b0);
        rd("unmapped read", 16'h0FF0, 32'h0, 1'b1);
        $display("test reset values done");

        wr(ADDR_BROWNOUT_CONTROL, 32'hFFFF_FFFF);
        rd("control unused bits", ADDR_BROWNOUT_CONTROL, 32'h81, 1'b0);
        wr(ADDR_RESET_FLAGS_HIGH, 32'hFFFF_FFF8);
        rd("high unused bits", ADDR_RESET_FLAGS_HIGH, 32'h0, 1'b0);
        strb = 4'h0;
        wr(ADDR_RESET_FLAGS_LOW, 32'h0);
        strb = 4'hF;
        wr(16'h0FF0, 32'h0);
        rd("low after ignored writes", ADDR_RESET_FLAGS_LOW, 32'h3D, 1'b0);
        $display("test ignored writes done");

        // Every configuration code, software bit and armed level
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 2; s++) begin
                for (int a = 0; a < 2; a++) begin
                    en = (c == 1) ? s[0] : c[1];
                    bor_cfg <= c[1:0];
                    armed   <= a[0];
                    wr(ADDR_BROWNOUT_CONTROL, {24'h0, s[0], 7'h0});
                    repeat (4) @(posedge clk);
                    check("detector enable", {31'h0, bor_en}, {31'h0, en});
                    rd("control", ADDR_BROWNOUT_CONTROL, {24'h0, s[0], 6'h0, en & a[0]}, 1'b0);
                end
            end
        end
        $display("test brown-out control done");

        // Each event from a state where its flag is inactive
        bor_cfg <= 2'h0;
        wr(ADDR_EVENT_MASK, 32'h3FF);
        for (int i = 0; i < EV_W; i++) begin
            en = (i < 2 || i == 9) ? 1'b0 : 1'b1;
            wr(ADDR_RESET_FLAGS_LOW, {24'h0, {8{en}}});
            wr(ADDR_RESET_FLAGS_HIGH, {29'h0, {3{en}}});
            wr(ADDR_BROWNOUT_CONTROL, 32'h0);
            pulse(i);
            repeat (2) @(posedge clk);
            check("irq raised", {31'h0, irq}, 32'h1);
            rd("low after event", ADDR_RESET_FLAGS_LOW, {24'h0, exp_lo[i]}, 1'b0);
            rd("high after event", ADDR_RESET_FLAGS_HIGH, {29'h0, exp_hi[i]}, 1'b0);
            rd("control after event", ADDR_BROWNOUT_CONTROL, (i == 6) ? 32'h80 : 32'h0, 1'b0);
            rd("status after event", ADDR_EVENT_STATUS, 32'h1 << i, 1'b0);
            wr(ADDR_EVENT_STATUS, 32'h1 << i);
            rd("status cleared", ADDR_EVENT_STATUS, 32'h0, 1'b0);
            check("irq cleared", {31'h0, irq}, 32'h0);
        end
        $display("test events done");

        wr(ADDR_EVENT_MASK, 32'h0);
        pulse(EV_STACK_OVF);
        repeat (2) @(posedge clk);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd("status masked", ADDR_EVENT_STATUS, 32'h1, 1'b0);
        wr(ADDR_EVENT_MASK, 32'h1);
        repeat (2) @(posedge clk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(ADDR_EVENT_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        check("irq after clear", {31'h0, irq}, 32'h0);
        $display("test interrupt mask done");

        // Clock enable low: a pulse in that time is not taken
        ce <= 1'b0;
        pulse(EV_STACK_OVF);
        ce <= 1'b1;
        rd("status frozen", ADDR_EVENT_STATUS, 32'h0, 1'b0);
        $display("test clock enable done");

        // Software writes of active levels raise no event
        wr(ADDR_EVENT_MASK, 32'h3FF);
        wr(ADDR_RESET_FLAGS_LOW, 32'hC0);
        wr(ADDR_RESET_FLAGS_HIGH, 32'h1);
        wr(ADDR_BROWNOUT_CONTROL, 32'h80);
        rd("low test write", ADDR_RESET_FLAGS_LOW, 32'hC0, 1'b0);
        rd("high test write", ADDR_RESET_FLAGS_HIGH, 32'h1, 1'b0);
        rd("status test write", ADDR_EVENT_STATUS, 32'h0, 1'b0);
        check("irq test write", {31'h0, irq}, 32'h0);
        rd("control test write", ADDR_BROWNOUT_CONTROL, 32'h80, 1'b0);
        $display("test software writes done");

        // Power-on reset in mid-run reloads the defaults
        wr(ADDR_BROWNOUT_CONTROL, 32'h0);
        wr(ADDR_RESET_FLAGS_LOW, 32'hFF);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd("low second reset", ADDR_RESET_FLAGS_LOW, 32'h3D, 1'b0);
        rd("high second reset", ADDR_RESET_FLAGS_HIGH, 32'h4, 1'b0);
        rd("control second reset", ADDR_BROWNOUT_CONTROL, 32'h80, 1'b0);
        rd("mask second reset", ADDR_EVENT_MASK, 32'h0, 1'b0);
        $display("test second reset done");
        end_sim();
    end
endmodule

//--- verilog/reset_cause_pkg.sv
package reset_cause_pkg;

    // Bus geometry
    localparam int          ADDR_W = 16;
    localparam int          DATA_W = 32;

    // Printed register indices; byte address is four times the index
    localparam logic [11:0] IDX_BROWNOUT_CONTROL     = 12'h049;
    localparam logic [11:0] IDX_RESET_FLAGS_LOW      = 12'h4F0;
    localparam logic [11:0] IDX_RESET_FLAGS_HIGH     = 12'h4F1;
    localparam logic [11:0] IDX_EVENT_STATUS         = 12'h4F2;
    localparam logic [11:0] IDX_EVENT_MASK           = 12'h4F3;

    localparam logic [ADDR_W-1:0] ADDR_BROWNOUT_CONTROL = {2'b00, IDX_BROWNOUT_CONTROL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RESET_FLAGS_LOW  = {2'b00, IDX_RESET_FLAGS_LOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RESET_FLAGS_HIGH = {2'b00, IDX_RESET_FLAGS_HIGH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS     = {2'b00, IDX_EVENT_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK       = {2'b00, IDX_EVENT_MASK, 2'b00};

    // Brown-out control field positions
    localparam int          POS_SW_BOR_EN    = 7;
    localparam int          POS_BOR_READY    = 0;

    // Low flag register field positions
    localparam int          POS_STACK_OVF    = 7;
    localparam int          POS_STACK_UNF    = 6;
    localparam int          POS_WDT_WINDOW   = 5;
    localparam int          POS_WDT_TIMEOUT  = 4;
    localparam int          POS_EXT_PIN      = 3;
    localparam int          POS_RESET_INSTR  = 2;
    localparam int          POS_POWER_ON     = 1;
    localparam int          POS_BROWNOUT     = 0;

    // High flag register field positions
    localparam int          HIGH_W           = 3;
    localparam int          POS_CORE_REG     = 2;
    localparam int          POS_MEM_VIOL     = 1;
    localparam int          POS_CFG_MEM      = 0;

    // Values loaded by power-on and by brown-out
    localparam logic [7:0]        LOW_POR_VALUE  = 8'h3D;
    localparam logic [HIGH_W-1:0] HIGH_POR_VALUE = 3'h4;
    localparam logic              SW_BOR_EN_POR  = 1'b1;

    // Brown-out configuration field code that hands control to software
    localparam logic [1:0]  BOR_CFG_SOFTWARE = 2'h1;

    // Event status bit positions
    localparam int          EV_W             = 10;
    localparam int          EV_STACK_OVF     = 0;
    localparam int          EV_STACK_UNF     = 1;
    localparam int          EV_WDT_WINDOW    = 2;
    localparam int          EV_WDT_TIMEOUT   = 3;
    localparam int          EV_EXT_PIN       = 4;
    localparam int          EV_RESET_INSTR   = 5;
    localparam int          EV_BROWNOUT      = 6;
    localparam int          EV_CORE_REG      = 7;
    localparam int          EV_MEM_VIOL      = 8;
    localparam int          EV_CFG_MEM       = 9;

endpackage

//--- verilog/reset_cause_regs.sv
// What this block does
// - Enable bit inert unless config field is 01
// - Config 01: enable bit drives detector; loads 1
// - Ready bit reads 1 only when armed
// - Stack overflow sets flag; power loss clears
// - Stack underflow sets flag; power loss clears
// - Window violation clears flag; power loss sets
// - Watchdog timeout clears flag; power loss sets
// - External pin reset clears flag; power loss sets
// - Reset instruction clears flag; power loss sets
// - Power-on clears power-on bit; else kept
// - Brown-out clears brown-out bit; power-on sets
// - Regulator fault clears flag; power loss sets
// - Memory violation clears flag; power loss clears
// - Config latch corruption sets flag; power loss clears
// - Each event except brown-out touches only its own flags
// - Software test writes never cause resets
//
// The implementer's own choice: register access over APB.
module reset_cause_regs
(
    input  wire logic                               clk,                   // System clock, 50 MHz
    input  wire logic                               reset,                 // Power-on reset, sync
    input  wire logic                               ce,                    // Clock enable
    input  wire logic                               psel,                  // APB select
    input  wire logic                               penable,               // APB enable
    input  wire logic                               pwrite,                // APB direction
    input  wire logic [reset_cause_pkg::ADDR_W-1:0] paddr,                 // APB byte address
    input  wire logic [reset_cause_pkg::DATA_W-1:0] pwdata,                // APB write data
    input  wire logic [3:0]                         pstrb,                 // APB byte strobes
    output logic      [reset_cause_pkg::DATA_W-1:0] prdata,                // APB read data
    output logic                                    pready,                // APB ready
    output logic                                    pslverr,               // APB error
    input  wire logic [1:0]                         brownout_config_field, // Fuse setting
    input  wire logic                               brownout_armed_pin,    // Analog ready, async
    input  wire logic                               brownout_event,        // Brown-out reset pulse
    input  wire logic                               stack_overflow_event,  // Stack overflow pulse
    input  wire logic                               stack_underflow_event, // Stack underflow pulse
    input  wire logic                               wdt_window_event,      // Window violation pulse
    input  wire logic                               wdt_timeout_event,     // Watchdog timeout pulse
    input  wire logic                               ext_pin_event,         // External pin reset pulse
    input  wire logic                               reset_instr_event,     // Reset instruction pulse
    input  wire logic                               core_reg_event,        // Regulator fault pulse
    input  wire logic                               mem_viol_event,        // Memory violation pulse
    input  wire logic                               cfg_mem_event,         // Latch corruption pulse
    output logic                                    brownout_enable,       // Detector enable
    output logic                                    irq                    // Level interrupt
);
    import reset_cause_pkg::*;

    // State
    logic                sw_brownout_enable_r;
    logic                sw_brownout_enable_nxt;
    logic                bor_en_r;
    logic                bor_en_nxt;
    logic [7:0]          flags_low_r;
    logic [7:0]          flags_low_nxt;
    logic [HIGH_W-1:0]   flags_high_r;
    logic [HIGH_W-1:0]   flags_high_nxt;
    logic [EV_W-1:0]     ev_status_r;
    logic [EV_W-1:0]     ev_status_nxt;
    logic [EV_W-1:0]     ev_mask_r;
    logic [EV_W-1:0]     ev_mask_nxt;
    logic                armed_meta_r;
    logic                armed_sync_r;
    logic [DATA_W-1:0]   prdata_r;
    logic [DATA_W-1:0]   prdata_nxt;
    logic                pready_r;
    logic                pready_nxt;
    logic                pslverr_r;
    logic                pslverr_nxt;
    logic                irq_r;
    logic                irq_nxt;

    // Decode helpers
    logic                setup_phase;
    logic                wr_take;
    logic                addr_hit;
    logic                brownout_ready;
    logic [DATA_W-1:0]   rd_val;
    logic [EV_W-1:0]     ev_vec;

    // Transfer phases: setup is seen once, the write lands on the access edge
    assign setup_phase = psel && !penable && !pready_r;
    assign wr_take     = psel && penable && pready_r && pwrite && pstrb[0];

    // Ready status only while the detector is on and the analog side is armed
    assign brownout_ready = armed_sync_r && bor_en_r;

    // Event vector in status bit order
    always_comb begin
        ev_vec                 = '0;
        ev_vec[EV_STACK_OVF]   = stack_overflow_event;
        ev_vec[EV_STACK_UNF]   = stack_underflow_event;
        ev_vec[EV_WDT_WINDOW]  = wdt_window_event;
        ev_vec[EV_WDT_TIMEOUT] = wdt_timeout_event;
        ev_vec[EV_EXT_PIN]     = ext_pin_event;
        ev_vec[EV_RESET_INSTR] = reset_instr_event;
        ev_vec[EV_BROWNOUT]    = brownout_event;
        ev_vec[EV_CORE_REG]    = core_reg_event;
        ev_vec[EV_MEM_VIOL]    = mem_viol_event;
        ev_vec[EV_CFG_MEM]     = cfg_mem_event;
    end

    // Read multiplexer and address decode
    always_comb begin
        rd_val   = '0;
        addr_hit = 1'b1;
        if (paddr == ADDR_BROWNOUT_CONTROL) begin
            rd_val[POS_SW_BOR_EN] = sw_brownout_enable_r;
            rd_val[POS_BOR_READY] = brownout_ready;
        end else if (paddr == ADDR_RESET_FLAGS_LOW) begin
            rd_val[7:0] = flags_low_r;
        end else if (paddr == ADDR_RESET_FLAGS_HIGH) begin
            rd_val[HIGH_W-1:0] = flags_high_r;
        end else if (paddr == ADDR_EVENT_STATUS) begin
            rd_val[EV_W-1:0] = ev_status_r;
        end else if (paddr == ADDR_EVENT_MASK) begin
            rd_val[EV_W-1:0] = ev_mask_r;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // Next state: software writes first, then brown-out load, then events
    always_comb begin
        sw_brownout_enable_nxt = sw_brownout_enable_r;
        bor_en_nxt             = bor_en_r;
        flags_low_nxt          = flags_low_r;
        flags_high_nxt         = flags_high_r;
        ev_status_nxt          = ev_status_r;
        ev_mask_nxt            = ev_mask_r;
        prdata_nxt             = prdata_r;
        pready_nxt             = pready_r;
        pslverr_nxt            = pslverr_r;
        irq_nxt                = irq_r;
        if (ce) begin
            // Bus answer one cycle after setup
            pready_nxt  = setup_phase;
            pslverr_nxt = setup_phase && !addr_hit;
            prdata_nxt  = (setup_phase && !pwrite) ? rd_val : '0;

            // Software writes; flags only store, no reset is raised
            if (wr_take) begin
                if (paddr == ADDR_BROWNOUT_CONTROL) begin
                    sw_brownout_enable_nxt = pwdata[POS_SW_BOR_EN];
                end else if (paddr == ADDR_RESET_FLAGS_LOW) begin
                    flags_low_nxt = pwdata[7:0];
                end else if (paddr == ADDR_RESET_FLAGS_HIGH) begin
                    flags_high_nxt = pwdata[HIGH_W-1:0];
                end else if (paddr == ADDR_EVENT_STATUS) begin
                    ev_status_nxt = ev_status_r & ~pwdata[EV_W-1:0];
                end else if (paddr == ADDR_EVENT_MASK) begin
                    ev_mask_nxt = pwdata[EV_W-1:0];
                end
            end

            // Brown-out loads defaults, keeping the power-on bit and clearing the brown-out bit
            if (brownout_event) begin
                sw_brownout_enable_nxt = SW_BOR_EN_POR;
                flags_low_nxt  = {LOW_POR_VALUE[7:2], flags_low_r[POS_POWER_ON], 1'b0};
                flags_high_nxt = HIGH_POR_VALUE;
            end

            // Each cause drives only its own flag to the active level
            if (stack_overflow_event) begin
                flags_low_nxt[POS_STACK_OVF] = 1'b1;
            end
            if (stack_underflow_event) begin
                flags_low_nxt[POS_STACK_UNF] = 1'b1;
            end
            if (wdt_window_event) begin
                flags_low_nxt[POS_WDT_WINDOW] = 1'b0;
            end
            if (wdt_timeout_event) begin
                flags_low_nxt[POS_WDT_TIMEOUT] = 1'b0;
            end
            if (ext_pin_event) begin
                flags_low_nxt[POS_EXT_PIN] = 1'b0;
            end
            if (reset_instr_event) begin
                flags_low_nxt[POS_RESET_INSTR] = 1'b0;
            end
            if (core_reg_event) begin
                flags_high_nxt[POS_CORE_REG] = 1'b0;
            end
            if (mem_viol_event) begin
                flags_high_nxt[POS_MEM_VIOL] = 1'b0;
            end
            if (cfg_mem_event) begin
                flags_high_nxt[POS_CFG_MEM] = 1'b1;
            end

            // Sticky event bits, set wins over a clearing write
            ev_status_nxt = ev_status_nxt | ev_vec;

            // Detector follows software only in the software setting
            if (brownout_config_field == BOR_CFG_SOFTWARE) begin
                bor_en_nxt = sw_brownout_enable_r;
            end else begin
                bor_en_nxt = brownout_config_field[1];
            end

            irq_nxt = |(ev_status_nxt & ev_mask_nxt);
        end
    end

    // Registers; power-on loads the documented values
    always_ff @(posedge clk) begin
        if (reset) begin
            sw_brownout_enable_r <= SW_BOR_EN_POR;
            bor_en_r             <= 1'b0;
            flags_low_r          <= LOW_POR_VALUE;
            flags_high_r         <= HIGH_POR_VALUE;
            ev_status_r          <= '0;
            ev_mask_r            <= '0;
            armed_meta_r         <= 1'b0;
            armed_sync_r         <= 1'b0;
            prdata_r             <= '0;
            pready_r             <= 1'b0;
            pslverr_r            <= 1'b0;
            irq_r                <= 1'b0;
        end else if (ce) begin
            sw_brownout_enable_r <= sw_brownout_enable_nxt;
            bor_en_r             <= bor_en_nxt;
            flags_low_r          <= flags_low_nxt;
            flags_high_r         <= flags_high_nxt;
            ev_status_r          <= ev_status_nxt;
            ev_mask_r            <= ev_mask_nxt;
            armed_meta_r         <= brownout_armed_pin;
            armed_sync_r         <= armed_meta_r;
            prdata_r             <= prdata_nxt;
            pready_r             <= pready_nxt;
            pslverr_r            <= pslverr_nxt;
            irq_r                <= irq_nxt;
        end
    end

    // Outputs straight from flops
    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign brownout_enable = bor_en_r;
    assign irq             = irq_r;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Hardware settings ignore the software bit; an edge that takes reset loads 0 instead
    a_bor_hw_mode: assert property (
        ce && !reset && brownout_config_field != BOR_CFG_SOFTWARE
        |=> brownout_enable == $past(brownout_config_field[1]))
        else $error("detector enable did not follow hardware setting");

    // Software setting follows the stored bit; an edge that takes reset loads 0 instead
    a_bor_sw_mode: assert property (
        ce && !reset && brownout_config_field == BOR_CFG_SOFTWARE
        |=> brownout_enable == $past(sw_brownout_enable_r))
        else $error("detector enable did not follow software bit");

    // Brown-out reloads the software enable
    a_sbor_reload: assert property (
        ce && brownout_event |=> sw_brownout_enable_r)
        else $error("software enable not reloaded on brown-out");

    // Ready never reads 1 with the detector off
    a_ready_read: assert property (
        ce && setup_phase && !pwrite && paddr == ADDR_BROWNOUT_CONTROL && !brownout_enable
        |=> pready && prdata[POS_BOR_READY] == 1'b0)
        else $error("ready bit read high while detector off");

    // Stack events raise their flags
    a_stack_flags: assert property (
        ce && (stack_overflow_event || stack_underflow_event)
        |=> (flags_low_r[POS_STACK_OVF] || !$past(stack_overflow_event))
         && (flags_low_r[POS_STACK_UNF] || !$past(stack_underflow_event)))
        else $error("stack flag not raised");

    // Low-active cause flags drop on their events
    a_low_causes: assert property (
        ce && (wdt_window_event || wdt_timeout_event || ext_pin_event || reset_instr_event)
        |=> !(flags_low_r[POS_WDT_WINDOW] && $past(wdt_window_event))
         && !(flags_low_r[POS_WDT_TIMEOUT] && $past(wdt_timeout_event))
         && !(flags_low_r[POS_EXT_PIN] && $past(ext_pin_event))
         && !(flags_low_r[POS_RESET_INSTR] && $past(reset_instr_event)))
        else $error("cause flag not cleared by its event");

    // Power-on bit holds without a software write
    a_por_hold: assert property (
        !(wr_take && paddr == ADDR_RESET_FLAGS_LOW)
        |=> $stable(flags_low_r[POS_POWER_ON]))
        else $error("power-on bit changed without a write");

    // Brown-out clears its bit and reloads the window bit
    a_bor_load: assert property (
        ce && brownout_event && !wdt_window_event
        |=> !flags_low_r[POS_BROWNOUT] && flags_low_r[POS_WDT_WINDOW])
        else $error("brown-out load wrong");

    // High register events
    a_high_causes: assert property (
        ce && (core_reg_event || mem_viol_event || cfg_mem_event)
        |=> !(flags_high_r[POS_CORE_REG] && $past(core_reg_event))
         && !(flags_high_r[POS_MEM_VIOL] && $past(mem_viol_event))
         && (flags_high_r[POS_CFG_MEM] || !$past(cfg_mem_event)))
        else $error("high cause flag wrong after event");

    // Unused bits read zero
    a_unused_zero: assert property (
        ce && setup_phase && !pwrite
        && (paddr == ADDR_RESET_FLAGS_HIGH || paddr == ADDR_BROWNOUT_CONTROL)
        |=> prdata[6:HIGH_W] == '0 && prdata[DATA_W-1:8] == '0)
        else $error("unused bits read nonzero");

    // Interrupt tracks masked status
    a_irq_level: assert property (
        irq == |(ev_status_r & ev_mask_r))
        else $error("interrupt does not match masked status");

    // Clock enable low freezes flags and status
    a_ce_freeze: assert property (
        !ce |=> $stable(flags_low_r) && $stable(flags_high_r) && $stable(ev_status_r))
        else $error("state changed while clock enable low");

endmodule
